// ==== rf_bias_pkg.sv ====
// package for the rf bias control block: register map, bit fields, states
// assumes a 32-bit axi4-lite register bus and a 100 MHz system clock
package rf_bias_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_B_ADDR = 8'h1C;
	localparam logic [7:0] RADIO_STATE_ADDR = 8'h20;
	localparam logic [7:0] PIN_STATUS_ADDR = 8'h24;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// control bit positions
	localparam int TOPO_BIT = 12;
	localparam int INV_BIT = 13;
	localparam int EN_BIT = 14;
	localparam logic [15:0] CTRL_B_RESET = 16'h0000;
	// radio operating state codes, one-hot
	typedef enum logic [5:0] {
		RADIO_OFF = 6'b00_0001,
		RADIO_IDLE = 6'b00_0010,
		RADIO_DOZE = 6'b00_0100,
		RADIO_HIBERNATE = 6'b00_1000,
		RADIO_RX = 6'b01_0000,
		RADIO_TX = 6'b10_0000
	} radio_state_t;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rf_bias_pkg

// ==== axil_ctrl_regs.sv ====
// axi4-lite slave holding the control register and the radio state register
// assumes one outstanding write and one outstanding read from the master
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module axil_ctrl_regs
	import rf_bias_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [DATA_W-1:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [DATA_W-1:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic [1:0] pin_status,
	output logic [15:0] ctrl_b,
	output radio_state_t radio_state
);
	logic aw_held_reg;
	logic w_held_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic [15:0] ctrl_b_reg;
	radio_state_t state_reg;
	logic [1:0] bresp_reg;
	logic bvalid_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rvalid_reg;
	logic awready_reg;
	logic wready_reg;
	logic arready_reg;

	// write path: capture address and data in either order
	wire logic aw_take = s_awvalid && !aw_held_reg && !bvalid_reg;
	wire logic w_take = s_wvalid && !w_held_reg && !bvalid_reg;
	wire logic do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire logic wr_ctrl = do_write && (awaddr_reg == CTRL_B_ADDR);
	wire logic wr_state = do_write && (awaddr_reg == RADIO_STATE_ADDR);
	wire logic wr_known = wr_ctrl || wr_state;
	wire logic [15:0] ctrl_merge = {wstrb_reg[1] ? wdata_reg[15:8] :
		ctrl_b_reg[15:8], wstrb_reg[0] ? wdata_reg[7:0] : ctrl_b_reg[7:0]};
	// only one-hot codes are accepted as a radio state
	wire logic state_ok = wstrb_reg[0] && ($countones(wdata_reg[5:0]) == 1)
		&& (wdata_reg[DATA_W-1:6] == '0);

	// next holding and answer state, so the ready lines can be flops
	wire logic aw_held_next = aw_take || (aw_held_reg && !do_write);
	wire logic w_held_next = w_take || (w_held_reg && !do_write);
	wire logic bvalid_next = do_write || (bvalid_reg && !s_bready);

	assign s_awready = awready_reg;
	assign s_wready = wready_reg;
	assign s_bresp = bresp_reg;
	assign s_bvalid = bvalid_reg;

	// address and data holding stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else begin
			if (aw_take) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (w_take) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_wdata;
				wstrb_reg <= s_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// register update and write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_b_reg <= CTRL_B_RESET;
			state_reg <= RADIO_IDLE;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (wr_ctrl) begin
				ctrl_b_reg <= ctrl_merge;
			end
			if (wr_state && state_ok) begin
				state_reg <= radio_state_t'(wdata_reg[5:0]);
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_known && (!wr_state || state_ok)) ?
					RESP_OKAY : RESP_SLVERR;
			end else if (s_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// read path
	wire logic ar_take = s_arvalid && !rvalid_reg;
	wire logic rvalid_next = ar_take || (rvalid_reg && !s_rready);
	wire logic [DATA_W-1:0] rd_mux =
		(s_araddr == CTRL_B_ADDR) ? {16'h0000, ctrl_b_reg} :
		(s_araddr == RADIO_STATE_ADDR) ? {26'h000_0000, state_reg} :
		(s_araddr == PIN_STATUS_ADDR) ? {30'h0000_0000, pin_status} :
		32'h0000_0000;
	wire logic rd_known = (s_araddr == CTRL_B_ADDR) ||
		(s_araddr == RADIO_STATE_ADDR) || (s_araddr == PIN_STATUS_ADDR);

	// ready flops track the held and answer state one for one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			arready_reg <= 1'b1;
		end else begin
			awready_reg <= !aw_held_next && !bvalid_next;
			wready_reg <= !w_held_next && !bvalid_next;
			arready_reg <= !rvalid_next;
		end
	end

	assign s_arready = arready_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;
	assign s_rvalid = rvalid_reg;
	assign ctrl_b = ctrl_b_reg;
	assign radio_state = state_reg;

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
endmodule : axil_ctrl_regs
`default_nettype wire

// ==== bias_level_decode.sv ====
// pure decode of the bias pin level and drive from the control bits
// assumes all inputs are already on the system clock
`timescale 1ns/10ps
`default_nettype none
module bias_level_decode
	import rf_bias_pkg::*;
(
	input wire logic bias_out_enable,
	input wire logic bias_polarity_invert,
	input wire logic port_topology_select,
	input wire radio_state_t radio_state,
	output logic level,
	output logic drive
);
	// transmit sense, inverted only in dual port topology
	wire logic is_tx = (radio_state == RADIO_TX);
	wire logic is_rx = (radio_state == RADIO_RX);
	wire logic use_inv = !port_topology_select && bias_polarity_invert;
	wire logic active_level = is_tx ^ use_inv;
	// idle, doze, hibernate and off hold low; off is undefined anyway
	assign level = (is_tx || is_rx) ? active_level : 1'b0;
	assign drive = bias_out_enable;
endmodule : bias_level_decode
`default_nettype wire

// ==== rf_bias_pin_control.sv ====
// top of the rf bias control block: register slave plus pin driver
// assumes the radio state register is written by the modem sequencer
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - drive pin only when enable set
// - level from topology, then tx/rx
// - single port: tx high, rx low
// - dual port: invert flips tx/rx sense
// - idle, doze, hibernate drive low
// - enable is bit 14, resets zero
// - invert is bit 13, resets zero
// - topology is bit 12, zero dual
module rf_bias_pin_control
	import rf_bias_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [DATA_W-1:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [DATA_W-1:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	output logic rf_bias_control_out_o,
	output logic rf_bias_control_out_oe_n
);
	logic [15:0] ctrl_b;
	radio_state_t radio_state;
	logic level;
	logic drive;
	logic level_reg;
	logic oe_n_reg;

	// control bit fields
	wire logic bias_out_enable = ctrl_b[EN_BIT];
	wire logic bias_polarity_invert = ctrl_b[INV_BIT];
	wire logic port_topology_select = ctrl_b[TOPO_BIT];

	axil_ctrl_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid),
		.s_awready(s_awready),
		.s_wdata(s_wdata),
		.s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid),
		.s_wready(s_wready),
		.s_bresp(s_bresp),
		.s_bvalid(s_bvalid),
		.s_bready(s_bready),
		.s_araddr(s_araddr),
		.s_arvalid(s_arvalid),
		.s_arready(s_arready),
		.s_rdata(s_rdata),
		.s_rresp(s_rresp),
		.s_rvalid(s_rvalid),
		.s_rready(s_rready),
		.pin_status({oe_n_reg, level_reg}),
		.ctrl_b(ctrl_b),
		.radio_state(radio_state)
	);

	bias_level_decode u_decode (
		.bias_out_enable(bias_out_enable),
		.bias_polarity_invert(bias_polarity_invert),
		.port_topology_select(port_topology_select),
		.radio_state(radio_state),
		.level(level),
		.drive(drive)
	);

	// registered pin driver; released (oe_n high) after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			level_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			level_reg <= drive ? level : 1'b0;
			oe_n_reg <= !drive;
		end
	end

	assign rf_bias_control_out_o = level_reg;
	assign rf_bias_control_out_oe_n = oe_n_reg;
endmodule : rf_bias_pin_control
`default_nettype wire

// ==== bias_load.sv ====
// far-side load on the bias pin: balun or antenna switch input
// assumes the pin floats with no pull when the block releases it
`timescale 1ns/10ps
`default_nettype none
module bias_load (
	input wire logic aclk,
	input wire logic o,
	input wire logic oe_n,
	output logic level
);
	logic last_reg;
	// remember the driven level, show its inverse when floating
	always_ff @(posedge aclk) begin
		if (!oe_n) last_reg <= o;
	end
	assign level = oe_n ? ~last_reg : o;
endmodule : bias_load
`default_nettype wire

// ==== rf_bias_monitor.sv ====
// checker on the top ports: bus handshakes and bias pin drive
// assumes it is bound into the top module
`timescale 1ns/10ps
`default_nettype none
module rf_bias_monitor
	import rf_bias_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_awvalid,
	input wire logic s_awready,
	input wire logic s_wvalid,
	input wire logic s_wready,
	input wire logic s_bvalid,
	input wire logic s_bready,
	input wire logic s_arvalid,
	input wire logic s_arready,
	input wire logic s_rvalid,
	input wire logic s_rready,
	input wire logic [DATA_W-1:0] s_rdata,
	input wire logic rf_bias_control_out_o,
	input wire logic rf_bias_control_out_oe_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pin released by reset, parked low when released
	chk_reset_hiz: assert property ($rose(aresetn) |-> rf_bias_control_out_oe_n)
		else $error("pin driven after reset");
	chk_off_low: assert property (rf_bias_control_out_oe_n |-> !rf_bias_control_out_o)
		else $error("released pin not parked low");
	// answers stand and arrive on time
	chk_b_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
		else $error("write answer dropped early");
	chk_r_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
		else $error("read answer changed early");
	chk_ar_block: assert property (s_rvalid |-> !s_arready)
		else $error("read taken while answer pending");
	chk_aw_block: assert property (s_bvalid |-> !s_awready && !s_wready)
		else $error("write taken while answer pending");
	chk_r_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
		else $error("write answer late");
endmodule : rf_bias_monitor
bind rf_bias_pin_control rf_bias_monitor mon (.aclk(aclk), .aresetn(aresetn),
	.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid),
	.s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
	.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
	.s_rready(s_rready), .s_rdata(s_rdata),
	.rf_bias_control_out_o(rf_bias_control_out_o),
	.rf_bias_control_out_oe_n(rf_bias_control_out_oe_n));
`default_nettype wire

// ==== rf_bias_pin_control_tb.sv ====
// testbench: register writes sweep every control against idle, doze, hibernate, rx and tx
// assumes the bias load model and the bound checker are compiled
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module rf_bias_pin_control_tb;
	import rf_bias_pkg::*;
	logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
	logic s_arvalid = 0, s_rready = 0, s_awready, s_wready, s_bvalid;
	logic s_arready, s_rvalid, o, oe_n, seen, en, inv, tp, tx, lv;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0000_0000, s_rdata, d;
	logic [3:0] s_wstrb = 4'hf;
	logic [1:0] s_bresp, s_rresp, r;
	int mismatches = 0, total_checks = 0, cyc = 0;
	always #5 aclk = ~aclk;
	rf_bias_pin_control dut (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.rf_bias_control_out_o(o), .rf_bias_control_out_oe_n(oe_n));
	bias_load load (.aclk(aclk), .o(o), .oe_n(oe_n), .level(seen));
	// one bus write, ready raised two cycles after the handshake, a cycle after the answer, so the answer waits one cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= v;
		s_awvalid <= 1;
		s_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_awvalid && s_awready) s_awvalid <= 0;
			if (s_wvalid && s_wready) s_wvalid <= 0;
		end while (s_awvalid || s_wvalid);
		@(posedge aclk);
		s_bready <= 1;
		do @(posedge aclk); while (!s_bvalid);
		r = s_bresp;
		s_bready <= 0;
	endtask : wr
	// one bus read, same late ready
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 0;
		@(posedge aclk);
		s_rready <= 1;
		do @(posedge aclk); while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 0;
	endtask : rd
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// hang guard
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			end_of_test();
		end
	end
	// reset, bad address, then sweep controls against radio states
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(CTRL_B_ADDR);
		`CHK("ctrl reset", 32'h0000_0000, d)
		`CHK("oe_n reset", 1'b1, oe_n)
		wr(8'h10, 32'h0000_4000);
		`CHK("bad wr", RESP_SLVERR, r)
		rd(8'h10);
		`CHK("bad rd", RESP_SLVERR, r)
		wr(RADIO_STATE_ADDR, 32'h0000_0003);
		`CHK("bad state", RESP_SLVERR, r)
		rd(RADIO_STATE_ADDR);
		`CHK("state kept", 32'(RADIO_IDLE), d)
		for (int c = 0; c < 8; c++) begin
			for (int s = 0; s < 5; s++) begin
				{en, inv, tp} = c[2:0];
				tx = (s == 4);
				lv = en && (s > 2) && (tp ? tx : tx ^ inv);
				wr(CTRL_B_ADDR, 32'(c) << TOPO_BIT);
				wr(RADIO_STATE_ADDR, 32'(6'h02 << s));
				rd(CTRL_B_ADDR);
				`CHK("ctrl", 32'(c) << TOPO_BIT, d)
				`CHK("oe_n", !en, oe_n)
				if (en) `CHK("level", (s > 2) && (tp ? tx : tx ^ inv), seen)
				rd(PIN_STATUS_ADDR);
				`CHK("pin status", 32'({!en, lv}), d)
			end
		end
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		`CHK("oe_n rerst", 1'b1, oe_n)
		end_of_test();
	end
endmodule : rf_bias_pin_control_tb
`default_nettype wire
